//--- hdl/sgcc_pkg.sv
package sgcc_pkg;

	// ------------------------------------------------------------
	// Feature register layout
	// ------------------------------------------------------------
	localparam int WBE_MASK_BIT  = 3;
	localparam int FEATURE_WIDTH = 8;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 5;
	localparam int ASYNC_HOLD_CLK = 2;

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		SG_RUN,
		SG_FLUSH,
		SG_DRAIN,
		SG_ACK,
		SG_WAIT_WBE,
		SG_GRANT,
		SG_CLKSTOP
	} sgcc_state_type;

endpackage : sgcc_pkg

//--- hdl/sgcc_sync.sv
`timescale 1ns/1ps

module sgcc_sync (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Level in and out
	input  wire logic levelIn,
	output logic      levelOut
);

	logic stage1;

	// ------------------------------------------------------------
	// Two-stage synchroniser
	// ------------------------------------------------------------
	// The request may be driven asynchronously, so it is resynchronised.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1   <= 1'b0;
			levelOut <= 1'b0;
		end else begin
			stage1   <= levelIn;
			levelOut <= stage1;
		end
	end

endmodule : sgcc_sync

//--- hdl/sgcc_stop_grant.sv
`timescale 1ns/1ps

module sgcc_stop_grant (
	// Clock and reset
	input  wire logic                                core_clk,
	input  wire logic                                reset_n,
	// System logic
	input  wire logic                                stop_request_n,
	input  wire logic                                bus_clk_stopped,
	// Bus-cycle logic
	input  wire logic                                instrBoundary,
	input  wire logic                                pipeFlushDone,
	input  wire logic                                busIdle,
	input  wire logic                                burst_ready_n,
	input  wire logic                                write_buffer_empty_n,
	input  wire logic [sgcc_pkg::FEATURE_WIDTH-1:0]  extended_feature_reg,
	// Status and control
	output logic                                     pipeFlushReq,
	output logic                                     holdNewCycles,
	output logic                                     specialCycleReq,
	output logic                                     internalClkEnable,
	output logic                                     stopGrant,
	output logic                                     stopClock
);
	import sgcc_pkg::*;

	sgcc_state_type state;
	sgcc_state_type next_state;
	logic           stopReq;
	logic           ackSeen;
	logic           wbeOk;

	// ------------------------------------------------------------
	// Request input
	// ------------------------------------------------------------
	// The synchroniser covers the two-clock asynchronous width.
	sgcc_sync sgcc_sync_inst (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.levelIn  (~stop_request_n),
		.levelOut (stopReq)
	);

	// Buffer-empty counts as met when masked.
	assign wbeOk = extended_feature_reg[WBE_MASK_BIT] | ~write_buffer_empty_n;

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			SG_RUN:      if (stopReq && instrBoundary) next_state = SG_FLUSH;
			SG_FLUSH:    if (pipeFlushDone) next_state = SG_DRAIN;
			SG_DRAIN:    if (busIdle) next_state = SG_ACK;
			SG_ACK:      if (!burst_ready_n) next_state = SG_WAIT_WBE;
			SG_WAIT_WBE: if (wbeOk) next_state = SG_GRANT;
			SG_GRANT: begin
				if (bus_clk_stopped) next_state = SG_CLKSTOP;
				else if (!stopReq) next_state = SG_RUN;
			end
			SG_CLKSTOP:  if (!bus_clk_stopped) next_state = SG_GRANT;
			default:     next_state = SG_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) state <= SG_RUN;
		else state <= next_state;
	end

	// Remembers that ready was seen for the special cycle, so a halt can be traced back to it.
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) ackSeen <= 1'b0;
		else ackSeen <= (state == SG_ACK) ? !burst_ready_n : (state == SG_WAIT_WBE) && ackSeen;
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			pipeFlushReq      <= 1'b0;
			holdNewCycles     <= 1'b0;
			specialCycleReq   <= 1'b0;
			internalClkEnable <= 1'b1;
			stopGrant         <= 1'b0;
			stopClock         <= 1'b0;
		end else begin
			pipeFlushReq      <= (next_state == SG_FLUSH);
			holdNewCycles     <= (next_state != SG_RUN);
			specialCycleReq   <= (next_state == SG_ACK);
			internalClkEnable <= (next_state != SG_GRANT) && (next_state != SG_CLKSTOP);
			stopGrant         <= (next_state == SG_GRANT) || (next_state == SG_CLKSTOP);
			stopClock         <= (next_state == SG_CLKSTOP);
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_halt_needs_wbe;
		@(posedge core_clk) disable iff (!reset_n)
		$fell(internalClkEnable) |-> $past(wbeOk);
	endproperty
	a_halt_needs_wbe: assert property (p_halt_needs_wbe)
		else $error("clock halted without buffer empty");

	property p_halt_after_ready;
		@(posedge core_clk) disable iff (!reset_n)
		$fell(internalClkEnable) |-> $past(ackSeen) && $past(state) == SG_WAIT_WBE;
	endproperty
	a_halt_after_ready: assert property (p_halt_after_ready)
		else $error("clock halted before ready");

	property p_flush_first;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(pipeFlushReq) |-> $past(stopReq) && $past(instrBoundary);
	endproperty
	a_flush_first: assert property (p_flush_first)
		else $error("flush without boundary request");

	property p_ack_after_idle;
		@(posedge core_clk) disable iff (!reset_n)
		$rose(specialCycleReq) |-> $past(busIdle) && $past(state) == SG_DRAIN;
	endproperty
	a_ack_after_idle: assert property (p_ack_after_idle)
		else $error("ack before bus idle");

	property p_masked;
		@(posedge core_clk) disable iff (!reset_n)
		state == SG_WAIT_WBE && extended_feature_reg[WBE_MASK_BIT] |=> stopGrant;
	endproperty
	a_masked: assert property (p_masked)
		else $error("masked input still waited on");

	property p_stopclk;
		@(posedge core_clk) disable iff (!reset_n)
		stopGrant && bus_clk_stopped |=> stopClock && !internalClkEnable;
	endproperty
	a_stopclk: assert property (p_stopclk)
		else $error("stop-clock not entered");

	property p_resume;
		@(posedge core_clk) disable iff (!reset_n)
		state == SG_GRANT && !bus_clk_stopped && !stopReq |=> internalClkEnable && !stopGrant;
	endproperty
	a_resume: assert property (p_resume)
		else $error("no resume after negation");

	property p_grant_clk;
		@(posedge core_clk) disable iff (!reset_n)
		stopGrant |-> !internalClkEnable;
	endproperty
	a_grant_clk: assert property (p_grant_clk)
		else $error("clock runs in stop-grant");

	// The special cycle stays open until ready; the halt never shares that edge.
	property p_ack_until_ready;
		@(posedge core_clk) disable iff (!reset_n)
		specialCycleReq && burst_ready_n |=> specialCycleReq;
	endproperty
	a_ack_until_ready: assert property (p_ack_until_ready)
		else $error("special cycle dropped before ready");

	property p_ready_ends_ack;
		@(posedge core_clk) disable iff (!reset_n)
		specialCycleReq && !burst_ready_n |=> !specialCycleReq && internalClkEnable;
	endproperty
	a_ready_ends_ack: assert property (p_ready_ends_ack)
		else $error("special cycle not closed by ready");

	// An unmasked busy write buffer must keep the clock running.
	property p_wait_wbe;
		@(posedge core_clk) disable iff (!reset_n)
		state == SG_WAIT_WBE && !extended_feature_reg[WBE_MASK_BIT] && write_buffer_empty_n
			|=> internalClkEnable && !stopGrant;
	endproperty
	a_wait_wbe: assert property (p_wait_wbe)
		else $error("clock halted while buffer busy");

	property p_flush_until_done;
		@(posedge core_clk) disable iff (!reset_n)
		pipeFlushReq && !pipeFlushDone |=> pipeFlushReq;
	endproperty
	a_flush_until_done: assert property (p_flush_until_done)
		else $error("flush dropped before done");

	property p_boundary_only;
		@(posedge core_clk) disable iff (!reset_n)
		state == SG_RUN && !(stopReq && instrBoundary) |=> !pipeFlushReq && !holdNewCycles;
	endproperty
	a_boundary_only: assert property (p_boundary_only)
		else $error("request acted on off a boundary");

	property p_hold_grant;
		@(posedge core_clk) disable iff (!reset_n)
		stopGrant && stopReq && !bus_clk_stopped |=> stopGrant && !internalClkEnable;
	endproperty
	a_hold_grant: assert property (p_hold_grant)
		else $error("stop-grant left while requested");

	property p_clkstop_exit;
		@(posedge core_clk) disable iff (!reset_n)
		stopClock && !bus_clk_stopped |=> !stopClock && stopGrant;
	endproperty
	a_clkstop_exit: assert property (p_clkstop_exit)
		else $error("stop-clock kept with bus clock running");

	c_grant:   cover property (@(posedge core_clk) disable iff (!reset_n) $rose(stopGrant));
	c_stopclk: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(stopClock));
	c_resume:  cover property (@(posedge core_clk) disable iff (!reset_n) $fell(stopGrant));
	c_masked:  cover property (@(posedge core_clk) disable iff (!reset_n)
		state == SG_WAIT_WBE && extended_feature_reg[WBE_MASK_BIT]);
	c_flush:   cover property (@(posedge core_clk) disable iff (!reset_n) $rose(pipeFlushReq));

endmodule : sgcc_stop_grant

//--- testbench/sgcc_sys_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// System logic model
// ------------------------------------------------------------
module sgcc_sys_model (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic reset_n,
	// Bench control
	input  wire logic wantStop,
	input  wire logic wantClkStop,
	// Device status
	input  wire logic specialCycleReq,
	input  wire logic stopGrant,
	// Stop request side
	output logic      stop_request_n,
	output logic      bus_clk_stopped
);
	logic ackSeen;

	// The request is never dropped early, even if the bench asks, so the ack always completes.
	always_ff @(negedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stop_request_n <= 1'h1;
			ackSeen        <= 1'h0;
		end else if (wantStop) begin
			stop_request_n <= 1'h0;
			ackSeen        <= ackSeen | specialCycleReq;
		end else if (ackSeen && !specialCycleReq) begin
			stop_request_n <= 1'h1;
			ackSeen        <= 1'h0;
		end
	end

	always_ff @(negedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			bus_clk_stopped <= 1'h0;
		end else begin
			bus_clk_stopped <= wantClkStop && stopGrant && !stop_request_n;
		end
	end
endmodule : sgcc_sys_model

//--- testbench/sgcc_stop_grant_test.sv
`timescale 1ns/1ps

module sgcc_stop_grant_test;
	import sgcc_pkg::*;
	logic       core_clk = 1'h0;
	logic       reset_n = 1'h0;
	logic       wantStop = 1'h0;
	logic       wantClkStop = 1'h0;
	logic       instrBoundary = 1'h0;
	logic       pipeFlushDone = 1'h0;
	logic       busIdle = 1'h0;
	logic       burst_ready_n = 1'h1;
	logic       write_buffer_empty_n = 1'h1;
	logic [7:0] extended_feature_reg = 8'h00;
	logic       stop_request_n, bus_clk_stopped, pipeFlushReq, holdNewCycles;
	logic       specialCycleReq, internalClkEnable, stopGrant, stopClock;
	int         n_mismatch = 0;
	int         compares = 0;

	always #(CLK_PERIOD_NS / 2.0) core_clk = ~core_clk;

	sgcc_sys_model sgcc_sys_model_inst (.core_clk(core_clk), .reset_n(reset_n),
		.wantStop(wantStop), .wantClkStop(wantClkStop), .specialCycleReq(specialCycleReq),
		.stopGrant(stopGrant),
		.stop_request_n(stop_request_n), .bus_clk_stopped(bus_clk_stopped));

	sgcc_stop_grant sgcc_stop_grant_inst (.core_clk(core_clk), .reset_n(reset_n),
		.stop_request_n(stop_request_n), .bus_clk_stopped(bus_clk_stopped),
		.instrBoundary(instrBoundary), .pipeFlushDone(pipeFlushDone), .busIdle(busIdle),
		.burst_ready_n(burst_ready_n), .write_buffer_empty_n(write_buffer_empty_n),
		.extended_feature_reg(extended_feature_reg), .pipeFlushReq(pipeFlushReq),
		.holdNewCycles(holdNewCycles), .specialCycleReq(specialCycleReq),
		.internalClkEnable(internalClkEnable), .stopGrant(stopGrant), .stopClock(stopClock));

	task automatic step(input int n);
		repeat (n) @(negedge core_clk);
	endtask : step

	task automatic chk(input logic expVal, input logic got);
		compares++;
		if (got !== expVal) begin
			n_mismatch++;
			$display("BAD t=%0t expect=%h got=%h", $time, expVal, got);
		end
	endtask : chk

	task automatic stop_test;
		$display("mismatches=%0d compares=%0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : stop_test

	// ------------------------------------------------------------
	// Full entry, clock stop and resume; masked selects the feature bit
	// ------------------------------------------------------------
	task automatic enter_grant(input logic masked);
		extended_feature_reg = {4'h0, masked, 3'h0};
		wantStop <= 1'h1;
		step(ASYNC_HOLD_CLK + 4);
		chk(1'h0, pipeFlushReq);
		instrBoundary = 1'h1;
		step(3);
		chk(1'h1, pipeFlushReq);
		chk(1'h1, holdNewCycles);
		pipeFlushDone = 1'h1;
		step(3);
		chk(1'h0, specialCycleReq);
		busIdle = 1'h1;
		step(3);
		chk(1'h1, specialCycleReq);
		burst_ready_n = 1'h0;
		step(1);
		burst_ready_n = 1'h1;
		step(3);
		chk(masked ? 1'h0 : 1'h1, internalClkEnable);
		write_buffer_empty_n = 1'h0;
		step(3);
		chk(1'h0, internalClkEnable);
		chk(1'h1, stopGrant);
		wantClkStop <= 1'h1;
		step(3);
		chk(1'h1, stopClock);
		wantClkStop <= 1'h0;
		wantStop <= 1'h0;
		{instrBoundary, pipeFlushDone, busIdle} = 3'h0;
		write_buffer_empty_n = 1'h1;
		step(8);
		chk(1'h0, stopGrant);
		chk(1'h1, internalClkEnable);
		chk(1'h0, holdNewCycles);
	endtask : enter_grant

	// ------------------------------------------------------------
	// Outputs at their reset levels
	// ------------------------------------------------------------
	task automatic check_idle;
		chk(1'h0, pipeFlushReq);
		chk(1'h0, holdNewCycles);
		chk(1'h0, specialCycleReq);
		chk(1'h1, internalClkEnable);
		chk(1'h0, stopGrant);
		chk(1'h0, stopClock);
	endtask : check_idle

	// ------------------------------------------------------------
	// Reset in the middle of a flush, then released again
	// ------------------------------------------------------------
	task automatic reset_mid_run;
		wantStop <= 1'h1;
		instrBoundary = 1'h1;
		step(ASYNC_HOLD_CLK + 2);
		chk(1'h1, holdNewCycles);
		wantStop <= 1'h0;
		instrBoundary = 1'h0;
		reset_n = 1'h0;
		step(3);
		check_idle();
		reset_n = 1'h1;
		step(2);
		check_idle();
	endtask : reset_mid_run

	initial begin
		#(CLK_PERIOD_NS * 2000);
		n_mismatch++;
		stop_test();
	end

	initial begin
		step(3);
		reset_n = 1'h1;
		step(2);
		check_idle();
		enter_grant(1'h0);
		enter_grant(1'h1);
		reset_mid_run();
		stop_test();
	end
endmodule : sgcc_stop_grant_test
